// ===== src/phy_bmc_pkg.sv
// Shared constants and carriers for the basic mode control register block
package phy_bmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Management addressing
  localparam int unsigned ADDR_W = 5;                       // Register address width
  localparam int unsigned DATA_W = 16;                      // Register data width
  localparam logic [4:0] BMC_ADDR = 5'h00;                  // Basic mode control register
  localparam logic [4:0] XST_ADDR = 5'h1e;                  // Access-type status register

  ////////////////////////////////////////////////////////////////////////////
  // Basic mode control field positions
  localparam int unsigned BMC_RST_BIT = 15;                 // Software reset, self clearing
  localparam int unsigned BMC_LOOP_BIT = 14;                // MII loopback
  localparam int unsigned BMC_SPEED_BIT = 13;               // Manual speed, 1 = 100 Mb/s
  localparam int unsigned BMC_AN_BIT = 12;                  // Auto-negotiation enable
  localparam int unsigned BMC_DUPLEX_BIT = 8;               // Manual duplex, held below
  localparam int unsigned LOWER_W = 12;                     // Bits kept by adjoining logic
  localparam logic BMC_LOOP_RST = 1'h0;                     // Loopback value after reset

  ////////////////////////////////////////////////////////////////////////////
  // Access-type status register field positions
  localparam int unsigned XST_LINK_BIT = 15;                // Latched low link status
  localparam int unsigned XST_FAULT_BIT = 14;               // Latched high fault status
  localparam int unsigned XST_BUSY_BIT = 13;                // Self clearing reset event
  localparam int unsigned XST_FIX_LSB = 8;                  // Fixed read-only field
  localparam int unsigned XST_FIX_W = 4;                    // Fixed field width
  localparam logic [3:0] XST_FIX_VAL = 4'h5;                // Fixed value, arbitrary
  localparam int unsigned XST_CNT_W = 8;                    // Clear-on-read counter width

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;               // 100 MHz system clock
  localparam int unsigned SRST_TIME_NS = 1000;              // Software reset duration
  localparam int unsigned SRST_CYCLES =
    (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;     // Rounded up to cycles
  localparam int unsigned SRST_CNT_W = 16;                  // Reset counter width
  localparam logic [1:0] BOOT_WAIT = 2'h3;                  // Cycles before strap capture

  ////////////////////////////////////////////////////////////////////////////
  // Management request carrier
  typedef struct packed {
    logic rd;                                               // Read strobe
    logic wr;                                               // Write strobe
    logic [4:0] addr;                                       // Register address
    logic [15:0] wdata;                                     // Write data
  } mgmt_req_t;

endpackage

// ===== src/latch_until_read.sv
`timescale 1ns/1ns
`default_nettype none
// One status bit that latches its event and holds until the register is read
module latch_until_read #(
  parameter bit ACTIVE_LOW = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic evt,
  input wire logic rd_clr,
  output logic q
);

  localparam logic IDLE_V = ACTIVE_LOW ? 1'b1 : 1'b0;      // Value with no event seen
  localparam logic HIT_V = ~IDLE_V;                         // Value once the event hit

  logic q_r;                                                // Held status

  ////////////////////////////////////////////////////////////////////////////
  // Event wins over the read clear of the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q_r <= IDLE_V;
    end else if (ce) begin
      if (evt) begin
        q_r <= HIT_V;
      end else if (rd_clr) begin
        q_r <= IDLE_V;
      end
    end
  end

  assign q = q_r;

endmodule // latch_until_read
`default_nettype wire

// ===== src/clear_on_read_count.sv
`timescale 1ns/1ns
`default_nettype none
// Saturating event counter that returns to zero when it is read, or to one if an event comes in that cycle
module clear_on_read_count #(
  parameter int unsigned W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic inc,
  input wire logic rd_clr,
  output logic [W-1:0] q
);

  logic [W-1:0] cnt_r;                                      // Event count
  wire sat_w = &cnt_r;                                      // Count at its top

  ////////////////////////////////////////////////////////////////////////////
  // A read clears; an event in the read cycle starts the new count at one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (rd_clr) begin
        cnt_r <= W'(inc);
      end else if (inc && !sat_w) begin
        cnt_r <= cnt_r + W'(1);
      end
    end
  end

  assign q = cnt_r;

endmodule // clear_on_read_count
`default_nettype wire

// ===== src/phy_basic_control_upper.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Event bits set on event, self clear after
// - Clear-on-read fields ignore writes, zero after read unless an event hits the read cycle
// - Latched-low bit held low until read
// - Latched-high bit held high until read
// - Fixed read-only field always returns constant
// - Control register decoded at address zero
// - Bit 15 starts reset, reads one until done
// - Reset completion reloads strap configuration bits
// - Bit 14 loops MII transmit into receive
// - Bit 13 picks 100 or 10 Mb/s
// - Bit 12 enables auto-negotiation, strap default
// - Negotiation on ignores manual speed and duplex
// - Bit 8 picks full or half duplex
module phy_basic_control_upper #(
  parameter int unsigned SRST_CYCLES = phy_bmc_pkg::SRST_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire phy_bmc_pkg::mgmt_req_t mgmt_req,
  output logic mgmt_ack,
  output logic [15:0] mgmt_rdata,
  input wire logic [11:0] lower_rdata,
  output logic lower_wr,
  output logic [11:0] lower_wdata,
  input wire logic strap_speed_pin,
  input wire logic strap_an_pin,
  input wire logic link_ok,
  input wire logic fault_evt,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  input wire logic [3:0] mii_txd,
  input wire logic mii_tx_en,
  input wire logic [3:0] line_rxd,
  input wire logic line_rx_dv,
  output logic [3:0] mii_rxd,
  output logic mii_rx_dv,
  output logic soft_rst,
  output logic speed_100,
  output logic full_duplex,
  output logic an_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer states
  typedef enum logic [1:0] {
    ST_BOOT,                                                // Power-on strap capture
    ST_IDLE,                                                // Normal operation
    ST_RESET,                                               // Software reset running
    ST_RESTRAP                                              // Reload straps, then done
  } seq_state_t;

  localparam logic [15:0] SRST_LAST = 16'(SRST_CYCLES - 1); // Final count of the reset

  seq_state_t state_r, state_nxt;                           // Sequencer state
  logic [15:0] cnt_r, cnt_nxt;                              // Reset duration counter
  logic [1:0] boot_r;                                       // Wait for strap synchronisers
  logic loop_r;                                             // Loopback control
  logic speed_r;                                            // Manual speed control
  logic an_en_r;                                            // Auto-negotiation enable
  logic spd_s1_r, spd_s2_r;                                 // Speed strap synchroniser
  logic an_s1_r, an_s2_r;                                   // Negotiation strap synchroniser
  logic ack_r;                                              // Answer strobe
  logic [15:0] rdata_r;                                     // Answer data
  logic lwr_r;                                              // Lower write strobe
  logic [11:0] lwdata_r;                                    // Lower write data
  logic [3:0] rxd_r;                                        // Receive data to the MAC
  logic rxdv_r;                                             // Receive valid to the MAC
  logic spd_out_r, dup_out_r;                               // Resolved speed and duplex
  logic st_link, st_fault;                                  // Latched status bits
  logic [7:0] st_cnt;                                       // Fault event count

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and strobes
  wire take_w = ce && (mgmt_req.rd || mgmt_req.wr);         // Request accepted
  wire bmc_hit_w = mgmt_req.addr == phy_bmc_pkg::BMC_ADDR;
  wire xst_hit_w = mgmt_req.addr == phy_bmc_pkg::XST_ADDR;  // Access-type status hit
  wire busy_w = (state_r == ST_RESET) || (state_r == ST_RESTRAP); // Reset in progress
  wire bmc_wr_w = ce && mgmt_req.wr && bmc_hit_w && !busy_w; // Control write taken
  wire rst_req_w = bmc_wr_w && mgmt_req.wdata[phy_bmc_pkg::BMC_RST_BIT];
  wire xst_rd_w = ce && mgmt_req.rd && xst_hit_w;           // Read with side effects
  wire load_strap_w = (state_r == ST_RESTRAP)
    || ((state_r == ST_BOOT) && (boot_r == 2'h0));

  ////////////////////////////////////////////////////////////////////////////
  // Read data assembly
  wire [15:0] bmc_rd_w = {busy_w, loop_r, speed_r, an_en_r, lower_rdata};
  wire [15:0] xst_rd_data_w = {st_link, st_fault, busy_w, 1'b0,
    phy_bmc_pkg::XST_FIX_VAL, st_cnt};
  wire [15:0] rd_sel_w = bmc_hit_w ? bmc_rd_w
    : (xst_hit_w ? xst_rd_data_w : 16'h0000);               // Unmapped reads as zero

  ////////////////////////////////////////////////////////////////////////////
  // Effective speed and duplex selection
  wire spd_sel_w = an_en_r ? an_speed_100 : speed_r;
  wire dup_sel_w = an_en_r ? an_full_duplex
    : lower_rdata[phy_bmc_pkg::BMC_DUPLEX_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_BOOT: begin
        if (boot_r == 2'h0) begin
          state_nxt = ST_IDLE;                              // Straps captured
        end
      end
      ST_IDLE: begin
        if (rst_req_w) begin
          state_nxt = ST_RESET;
          cnt_nxt = 16'h0000;
        end
      end
      ST_RESET: begin
        if (cnt_r >= SRST_LAST) begin
          state_nxt = ST_RESTRAP;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      ST_RESTRAP: begin
        state_nxt = ST_IDLE;                                // Bit self clears
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_BOOT;
      cnt_r <= 16'h0000;
      boot_r <= phy_bmc_pkg::BOOT_WAIT;
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      if (boot_r != 2'h0) begin
        boot_r <= boot_r - 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap pin synchronisers, free of reset so they fill during it
  always_ff @(posedge clk) begin
    if (ce) begin
      spd_s1_r <= strap_speed_pin;
      spd_s2_r <= spd_s1_r;
      an_s1_r <= strap_an_pin;
      an_s2_r <= an_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bits: straps load at boot and at software reset completion
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      loop_r <= phy_bmc_pkg::BMC_LOOP_RST;
      speed_r <= 1'b0;
      an_en_r <= 1'b0;
    end else if (ce) begin
      if (load_strap_w) begin
        speed_r <= spd_s2_r;
        an_en_r <= an_s2_r;
        loop_r <= phy_bmc_pkg::BMC_LOOP_RST;
      end else if (bmc_wr_w && !rst_req_w) begin
        loop_r <= mgmt_req.wdata[phy_bmc_pkg::BMC_LOOP_BIT];
        speed_r <= mgmt_req.wdata[phy_bmc_pkg::BMC_SPEED_BIT];
        an_en_r <= mgmt_req.wdata[phy_bmc_pkg::BMC_AN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Management answer and pass-through to the lower bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      rdata_r <= 16'h0000;
      lwr_r <= 1'b0;
      lwdata_r <= 12'h000;
    end else if (ce) begin
      ack_r <= take_w;
      rdata_r <= mgmt_req.rd ? rd_sel_w : 16'h0000;
      lwr_r <= mgmt_req.wr && bmc_hit_w;
      lwdata_r <= mgmt_req.wdata[phy_bmc_pkg::LOWER_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive path mux and resolved mode outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxd_r <= 4'h0;
      rxdv_r <= 1'b0;
      spd_out_r <= 1'b0;
      dup_out_r <= 1'b0;
    end else if (ce) begin
      rxd_r <= loop_r ? mii_txd : line_rxd;
      rxdv_r <= loop_r ? mii_tx_en : line_rx_dv;
      spd_out_r <= spd_sel_w;
      dup_out_r <= dup_sel_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access-type status cells
  latch_until_read #(.ACTIVE_LOW(1'b1)) link_cell (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .evt(!link_ok),
    .rd_clr(xst_rd_w),
    .q(st_link)
  );

  latch_until_read #(.ACTIVE_LOW(1'b0)) fault_cell (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .evt(fault_evt),
    .rd_clr(xst_rd_w),
    .q(st_fault)
  );

  clear_on_read_count #(.W(phy_bmc_pkg::XST_CNT_W)) fault_count (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .inc(fault_evt),
    .rd_clr(xst_rd_w),
    .q(st_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output drive
  assign mgmt_ack = ack_r;
  assign mgmt_rdata = rdata_r;
  assign lower_wr = lwr_r;
  assign lower_wdata = lwdata_r;
  assign mii_rxd = rxd_r;
  assign mii_rx_dv = rxdv_r;
  assign soft_rst = busy_w;
  assign speed_100 = spd_out_r;
  assign full_duplex = dup_out_r;
  assign an_enable = an_en_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  rst_start_a: assert property (
    rst_req_w && state_r == ST_IDLE |=> busy_w && cnt_r == 16'h0000)
    else $error("software reset did not start");

  busy_read_a: assert property (
    take_w && mgmt_req.rd && bmc_hit_w
      |=> mgmt_rdata[phy_bmc_pkg::BMC_RST_BIT] == $past(busy_w))
    else $error("reset bit read back wrong");

  strap_reload_a: assert property (
    ce && state_r == ST_RESTRAP |=> speed_r == $past(spd_s2_r) && an_en_r == $past(an_s2_r)
      && !busy_w)
    else $error("straps not reloaded at reset end");

  loop_path_a: assert property (
    ce && loop_r |=> mii_rxd == $past(mii_txd) && mii_rx_dv == $past(mii_tx_en))
    else $error("loopback path wrong");

  manual_mode_a: assert property (
    ce && !an_en_r |=> speed_100 == $past(speed_r)
      && full_duplex == $past(lower_rdata[phy_bmc_pkg::BMC_DUPLEX_BIT]))
    else $error("manual speed or duplex not applied");

  an_mode_a: assert property (
    ce && an_en_r |=> speed_100 == $past(an_speed_100) && full_duplex == $past(an_full_duplex))
    else $error("manual bits not ignored under negotiation");

  pass_through_a: assert property (
    take_w && mgmt_req.rd && bmc_hit_w
      |=> mgmt_rdata[phy_bmc_pkg::LOWER_W-1:0] == $past(lower_rdata))
    else $error("lower bits not passed through");

  latch_low_a: assert property (
    ce && !link_ok ##1 ce && !xst_rd_w |=> !st_link)
    else $error("latched low bit released early");

  latch_high_a: assert property (
    ce && fault_evt ##1 ce && !xst_rd_w |=> st_fault)
    else $error("latched high bit released early");

  cor_clear_a: assert property (
    xst_rd_w && !fault_evt |=> st_cnt == 8'h00)
    else $error("counter not cleared by read");

  fixed_field_a: assert property (
    take_w && mgmt_req.rd && xst_hit_w
      |=> mgmt_rdata[phy_bmc_pkg::XST_FIX_LSB +: phy_bmc_pkg::XST_FIX_W]
        == phy_bmc_pkg::XST_FIX_VAL)
    else $error("fixed field changed");

endmodule // phy_basic_control_upper
`default_nettype wire

// ===== verification/mgmt_master_model.sv
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Station management master in front of the control register block
module mgmt_master_model (
  input wire logic clk,
  output var phy_bmc_pkg::mgmt_req_t mgmt_req,
  input wire logic mgmt_ack,
  input wire logic [15:0] mgmt_rdata
);
  int timeouts = 0;  // Answers that never came

  // Idle bus from time zero
  initial begin
    mgmt_req = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One request: strobe for one cycle, then wait a bounded time for the answer
  task automatic xfer(input logic rd, input logic [4:0] addr, input logic [15:0] wdata,
                      output logic [15:0] rdata);
    int n;
    @(posedge clk);
    #1;
    mgmt_req.rd = rd;
    mgmt_req.wr = ~rd;
    mgmt_req.addr = addr;
    mgmt_req.wdata = wdata;
    @(posedge clk);
    #1;
    mgmt_req.rd = 1'b0;
    mgmt_req.wr = 1'b0;
    // Released fields no longer show the last value
    mgmt_req.addr = ~addr;
    mgmt_req.wdata = ~wdata;
    rdata = 16'hxxxx;
    for (n = 0; n < 8; n++) begin
      // Answer strobe stands one cycle, so take the data now
      if (mgmt_ack === 1'b1) begin
        rdata = mgmt_rdata;
        return;
      end
      @(posedge clk);
      #1;
    end
    timeouts++;
  endtask
endmodule // mgmt_master_model
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the basic mode control register block
module testbench;
  logic clk = 1'b0;  // 100 MHz system clock
  logic sys_rst, ce;
  phy_bmc_pkg::mgmt_req_t mgmt_req;  // Driven by the management model
  logic mgmt_ack, lower_wr, soft_rst, speed_100, full_duplex, an_enable;
  logic [15:0] mgmt_rdata;
  logic [11:0] lower_rdata, lower_wdata;
  logic strap_speed_pin, strap_an_pin, link_ok, fault_evt, an_speed_100, an_full_duplex;
  logic [3:0] mii_txd, line_rxd, mii_rxd;
  logic mii_tx_en, line_rx_dv, mii_rx_dv;
  int fails = 0;
  int total_checks = 0;

  // Clock generator
  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Design and management master
  phy_basic_control_upper #(.SRST_CYCLES(8)) u_phy_basic_control_upper (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .mgmt_req(mgmt_req), .mgmt_ack(mgmt_ack),
    .mgmt_rdata(mgmt_rdata), .lower_rdata(lower_rdata), .lower_wr(lower_wr),
    .lower_wdata(lower_wdata), .strap_speed_pin(strap_speed_pin),
    .strap_an_pin(strap_an_pin), .link_ok(link_ok), .fault_evt(fault_evt),
    .an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex), .mii_txd(mii_txd),
    .mii_tx_en(mii_tx_en), .line_rxd(line_rxd), .line_rx_dv(line_rx_dv),
    .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv), .soft_rst(soft_rst),
    .speed_100(speed_100), .full_duplex(full_duplex), .an_enable(an_enable));

  mgmt_master_model u_mgmt_master_model (
    .clk(clk), .mgmt_req(mgmt_req), .mgmt_ack(mgmt_ack), .mgmt_rdata(mgmt_rdata));

  ////////////////////////////////////////////////////////////////////////////////
  // Access and compare helpers
  task automatic wr(input logic [4:0] addr, input logic [15:0] data);
    logic [15:0] dummy;
    u_mgmt_master_model.xfer(1'b0, addr, data, dummy);
  endtask

  task automatic rd(input logic [4:0] addr, output logic [15:0] data);
    u_mgmt_master_model.xfer(1'b1, addr, 16'h0000, data);
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    // Four-state compare so an unknown never matches
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    fails = fails + u_mgmt_master_model.timeouts;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #200000;
    fails++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [15:0] r;
    int i;
    int n;
    logic an, spd, dup;
    sys_rst = 1'b1;
    ce = 1'b1;
    lower_rdata = 12'h1a5;
    strap_speed_pin = 1'b1;
    strap_an_pin = 1'b0;
    link_ok = 1'b1;
    fault_evt = 1'b0;
    an_speed_100 = 1'b0;
    an_full_duplex = 1'b0;
    mii_txd = 4'ha;
    mii_tx_en = 1'b1;
    line_rxd = 4'h5;
    line_rx_dv = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    repeat (6) @(posedge clk);
    // Straps on bits 13/12, lower bits straight through, mode outputs follow
    rd(phy_bmc_pkg::BMC_ADDR, r);
    check("bmc_after_reset", r, 16'h21a5);
    check("full_duplex", {15'h0, full_duplex}, 16'h0001);
    check("rx_normal", {11'h0, mii_rx_dv, mii_rxd}, 16'h0005);
    // Loopback on, lower write data handed on
    wr(phy_bmc_pkg::BMC_ADDR, 16'h60c3);
    check("lower_wr", {3'h0, lower_wr, lower_wdata}, 16'h10c3);
    // Receive data trusted only after a settling wait
    repeat (3) @(posedge clk);
    #1;
    check("rx_loop", {11'h0, mii_rx_dv, mii_rxd}, 16'h001a);
    rd(phy_bmc_pkg::BMC_ADDR, r);
    check("bmc_loop", r, 16'h61a5);
    wr(phy_bmc_pkg::BMC_ADDR, 16'h2000);
    repeat (3) @(posedge clk);
    #1;
    check("rx_unloop", {11'h0, mii_rx_dv, mii_rxd}, 16'h0005);
    // Every combination of negotiation, manual speed and manual duplex
    for (i = 0; i < 8; i++) begin
      an = i[2];
      spd = i[1];
      dup = i[0];
      lower_rdata = {3'h0, dup, 8'h00};
      an_speed_100 = ~spd;
      an_full_duplex = ~dup;
      wr(phy_bmc_pkg::BMC_ADDR, {2'h0, spd, an, 12'h000});
      repeat (3) @(posedge clk);
      #1;
      check("an_enable", {15'h0, an_enable}, {15'h0, an});
      check("speed_100", {15'h0, speed_100}, {15'h0, an ? ~spd : spd});
      check("duplex", {15'h0, full_duplex}, {15'h0, an ? ~dup : dup});
    end
    lower_rdata = 12'h1a5;
    // Software reset with new straps and loopback set beforehand
    strap_speed_pin = 1'b0;
    strap_an_pin = 1'b1;
    wr(phy_bmc_pkg::BMC_ADDR, 16'h6000);
    wr(phy_bmc_pkg::BMC_ADDR, 16'h8000);
    check("soft_rst", {15'h0, soft_rst}, 16'h0001);
    rd(phy_bmc_pkg::BMC_ADDR, r);
    check("bmc_busy", {15'h0, r[15]}, 16'h0001);
    rd(phy_bmc_pkg::XST_ADDR, r);
    check("event_busy", {15'h0, r[13]}, 16'h0001);
    // Poll until the reset bit clears by itself
    n = 0;
    r = 16'hffff;
    while (r[15] !== 1'b0 && n < 20) begin
      rd(phy_bmc_pkg::BMC_ADDR, r);
      n++;
    end
    check("bmc_restrap", r, 16'h11a5);
    check("soft_rst_done", {15'h0, soft_rst}, 16'h0000);
    // Status latches, fixed field and clear-on-read count
    rd(phy_bmc_pkg::XST_ADDR, r);
    @(posedge clk);
    #1;
    link_ok = 1'b0;
    @(posedge clk);
    #1;
    link_ok = 1'b1;
    repeat (3) begin
      @(posedge clk);
      #1;
      fault_evt = 1'b1;
      @(posedge clk);
      #1;
      fault_evt = 1'b0;
    end
    wr(phy_bmc_pkg::XST_ADDR, 16'hffff);
    rd(phy_bmc_pkg::XST_ADDR, r);
    check("status_held", r, 16'h4503);
    rd(phy_bmc_pkg::XST_ADDR, r);
    check("status_cleared", r, 16'h8500);
    // Unmapped address reads as zero
    rd(5'h07, r);
    check("unmapped", r, 16'h0000);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
